// ---- include/pdt_map.svh ----
// Purpose: Register indices, field positions and reset values of the deadtime/trigger/polarity block.
// Assumes: Word index times four is the Wishbone byte address.
// Notes:   Definitions only.
`ifndef PDT_MAP_SVH
`define PDT_MAP_SVH

`define PDT_IDX_DEADTIME  8'h22
`define PDT_IDX_EXTTRIG   8'h23
`define PDT_IDX_POLARITY  8'h24
`define PDT_IDX_CTRL      8'h30
`define PDT_IDX_STATUS    8'h31
`define PDT_IDX_MASK      8'h32

`define PDT_DT_PS_MSB     7
`define PDT_DT_PS_LSB     6
`define PDT_DT_CNT_MSB    5
`define PDT_PS_DIV4       2'b10
`define PDT_PS_DIV16      2'b11

`define PDT_TRIGGER_FLAG_BIT     7
`define PDT_INIT_EN_BIT   6

`define PDT_CTRL_WRITE_PROTECT_DISABLE    0
`define PDT_CTRL_FLTEN    1
`define PDT_CTRL_WPON     2
`define PDT_CTRL_PAIR_DEADTIME_ENABLE_LSB 4

`define PDT_STS_TRIG      0
`define PDT_STS_FAULT     1

`define PDT_RST_BYTE      8'h00
`define PDT_RST_CTRL      8'h00

`endif

// ---- include/pdt_pkg.sv ----
// Purpose: State types of the deadtime/trigger/polarity block.
// Assumes: Each module keeps all of its state in one of these structs.
// Notes:   Constants live in pdt_map.svh.
package pdt_pkg;

	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
		logic [7:0] dt;
		logic [6:0] ext_en;
		logic       flag;
		logic       arm;
		logic [7:0] pol;
		logic       write_protect_disable;
		logic       fault_en;
		logic [3:0] pair_en;
		logic [1:0] sts;
		logic [1:0] mask;
		logic       irq;
		logic [7:0] pwm;
	} pdt_top_state_t;

	typedef struct packed {
		logic trig;
		logic chan_trig;
	} pdt_trig_state_t;

	typedef struct packed {
		logic [1:0][9:0] cnt;
		logic [1:0]      prev;
	} pdt_dt_state_t;

endpackage : pdt_pkg

// ---- include/pdt_cfg_if.sv ----
// Purpose: Configuration carried from the register file to the trigger and deadtime cells.
// Assumes: All signals are static levels held in registers of the top.
// Notes:   One source, several sinks.
`timescale 1ns/1ps
`default_nettype none
interface pdt_cfg_if;
	logic [1:0] prescale;
	logic [5:0] count;
	logic [5:0] trig_en;
	logic       init_en;

	modport src (output prescale, output count, output trig_en, output init_en);
	modport dt  (input prescale, input count);
	modport tg  (input trig_en, input init_en);
endinterface : pdt_cfg_if
`default_nettype wire

// ---- verilog/pdt_trigger.sv ----
// Purpose: Raises initialization and channel triggers from counter match pulses.
// Assumes: Match inputs are one-cycle pulses from the counter.
// Notes:   Matches of several channels in one cycle give a single pulse.
`timescale 1ns/1ps
`default_nettype none
module pdt_trigger
	import pdt_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	pdt_cfg_if.tg           cfg,
	input  wire logic [7:0] chan_match_i,
	input  wire logic       init_match_i,
	output logic            trig_o,
	output logic            chan_trig_o
);
	pdt_trig_state_t q, d;
	logic [5:0]      ch_en;

	always_comb begin
		// Enable bits are reordered into channel order 5..0.
		ch_en       = {cfg.trig_en[3:0], cfg.trig_en[5:4]};
		d.chan_trig = |(ch_en & chan_match_i[5:0]);
		d.trig      = d.chan_trig | (cfg.init_en & init_match_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign trig_o      = q.trig;
	assign chan_trig_o = q.chan_trig;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_init_trig_fires: assert property (cfg.init_en && init_match_i |=> trig_o)
		else $error("Initialization match did not raise a trigger.");
	chk_upper_chan_silent: assert property (chan_match_i[5:0] == 6'h00 && !init_match_i |=> !trig_o)
		else $error("Channel 6 or 7 raised a trigger.");
	chk_chan1_mapping: assert property (cfg.trig_en[5] && chan_match_i[1] |=> chan_trig_o)
		else $error("Channel 1 match with its enable gave no trigger.");
endmodule : pdt_trigger
`default_nettype wire

// ---- verilog/pdt_deadtime.sv ----
// Purpose: Deadtime insertion for one channel pair.
// Assumes: Inputs are active-high logical PWM levels.
// Notes:   Only inactive-to-active edges are delayed.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_map.svh"
module pdt_deadtime
	import pdt_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	pdt_cfg_if.dt           cfg,
	input  wire logic       en_i,
	input  wire logic [1:0] pwm_i,
	output logic      [1:0] pwm_o
);
	pdt_dt_state_t q, d;
	logic [9:0]    cycles;
	logic [1:0]    rise;

	always_comb begin
		unique case (cfg.prescale)
			`PDT_PS_DIV4:  cycles = {2'h0, cfg.count, 2'h0};
			`PDT_PS_DIV16: cycles = {cfg.count, 4'h0};
			default:       cycles = {4'h0, cfg.count};
		endcase
		d      = q;
		d.prev = pwm_i;
		rise   = pwm_i & ~q.prev;
		for (int i = 0; i < 2; i++) begin
			if (rise[i] && cycles != 10'h000) begin
				d.cnt[i] = cycles - 10'h001;
			end else if (q.cnt[i] != 10'h000) begin
				d.cnt[i] = q.cnt[i] - 10'h001;
			end
			if (!en_i) begin
				pwm_o[i] = pwm_i[i];
			end else if (rise[i]) begin
				pwm_o[i] = pwm_i[i] & (cycles == 10'h000);
			end else begin
				pwm_o[i] = pwm_i[i] & (q.cnt[i] == 10'h000);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_rise_held_off: assert property (en_i && rise[0] && cycles != 10'h000 |-> !pwm_o[0])
		else $error("Active edge passed without deadtime.");
	chk_count_loaded: assert property (rise[1] && cycles > 10'h001 |=> q.cnt[1] == $past(cycles) - 10'h001)
		else $error("Deadtime counter loaded with a wrong count.");
	chk_bypass_pair: assert property (!en_i |-> pwm_o == pwm_i)
		else $error("Deadtime applied to a disabled pair.");
	chk_fall_direct: assert property (!pwm_i[0] |-> !pwm_o[0])
		else $error("Inactive edge was delayed.");
endmodule : pdt_deadtime
`default_nettype wire

// ---- verilog/pdt_top.sv ----
// Purpose: Deadtime, external trigger and output polarity slice with a Wishbone register file.
// Assumes: Counter match pulses and raw PWM levels come from the timer core.
// Notes:   Registers are one byte each in the low lane of a 32-bit word.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_map.svh"
// Operation
// - Deadtime clock is system clock divided by 1, 4 or 16 by prescale.
// - All deadtime channels share one prescale and one count.
// - Deadtime equals prescale factor times count, zero inserts none, count up to 63, so at most 1008 cycles.
// - Prescale and count take writes only while protection is disabled.
// - Trigger flag bit 7 sets whenever a channel trigger occurs.
// - Flag clears by reading it set then writing zero; writing one does nothing.
// - A trigger between the read and the clearing write keeps the flag set.
// - Initialization trigger enable fires a trigger at counter initial value.
// - Channel enables fire on match; bits 5..0 map channels 1,0,5,4,3,2.
// - Channels 6 and 7 never produce channel triggers.
// - Several enabled channels matching in separate cycles each give their own trigger in one period; matches in one cycle give a single trigger.
// - Polarity bit n per channel: zero active high, one active low.
// - On an enabled fault each output goes to its polarity bit value.
// - Polarity bits take writes only while protection is disabled.
// - Deadtime applies to a pair only when its enable is one.
// - Write protect on status always reads as inverse of disable.
module pdt_top
	import pdt_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pwm_i,
	input  wire logic        init_match_i,
	input  wire logic [7:0]  chan_match_i,
	input  wire logic        fault_i,
	output logic      [7:0]  pwm_o,
	output logic             trig_o,
	output logic             chan_trig_o,
	output logic             irq_o
);
	pdt_top_state_t q, d;
	pdt_cfg_if      cfg ();

	logic [7:0] idx;
	logic       req;
	logic       rd_cap;
	logic       wr;
	logic [7:0] wdat;
	logic       fault_on;
	logic [7:0] dt_out;
	logic [7:0] rd_val;
	logic       chan_trig;

	assign idx      = wb_adr_i[9:2];
	assign req      = wb_cyc_i & wb_stb_i;
	assign rd_cap   = req & ~q.ack & ~wb_we_i;
	assign wr       = req & q.ack & wb_we_i & wb_sel_i[0];
	assign wdat     = wb_dat_i[7:0];
	assign fault_on = q.fault_en & fault_i;

	// One prescale and one count feed every pair.
	assign cfg.prescale = q.dt[`PDT_DT_PS_MSB:`PDT_DT_PS_LSB];
	assign cfg.count    = q.dt[`PDT_DT_CNT_MSB:0];
	assign cfg.trig_en  = q.ext_en[5:0];
	assign cfg.init_en  = q.ext_en[`PDT_INIT_EN_BIT];

	pdt_trigger u_trig (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.cfg          (cfg),
		.chan_match_i (chan_match_i),
		.init_match_i (init_match_i),
		.trig_o       (trig_o),
		.chan_trig_o  (chan_trig)
	);

	assign chan_trig_o = chan_trig;

	for (genvar p = 0; p < 4; p++) begin : g_pair
		pdt_deadtime u_dt (
			.clk_i (clk_i),
			.rst_i (rst_i),
			.cfg   (cfg),
			.en_i  (q.pair_en[p]),
			.pwm_i (pwm_i[2*p+1:2*p]),
			.pwm_o (dt_out[2*p+1:2*p])
		);
	end

	always_comb begin
		unique case (idx)
			`PDT_IDX_DEADTIME: begin
				rd_val = q.dt;
			end
			`PDT_IDX_EXTTRIG: begin
				rd_val = {q.flag, q.ext_en};
			end
			`PDT_IDX_POLARITY: begin
				rd_val = q.pol;
			end
			`PDT_IDX_CTRL: begin
				rd_val                   = `PDT_RST_CTRL;
				rd_val[`PDT_CTRL_WRITE_PROTECT_DISABLE]  = q.write_protect_disable;
				rd_val[`PDT_CTRL_FLTEN]  = q.fault_en;
				rd_val[`PDT_CTRL_WPON]   = ~q.write_protect_disable;
				rd_val[7:`PDT_CTRL_PAIR_DEADTIME_ENABLE_LSB] = q.pair_en;
			end
			`PDT_IDX_STATUS: begin
				rd_val = {6'h00, q.sts};
			end
			`PDT_IDX_MASK: begin
				rd_val = {6'h00, q.mask};
			end
			default: begin
				rd_val = 8'h00;
			end
		endcase
	end

	always_comb begin
		d       = q;
		d.ack   = req & ~q.ack;
		d.rdata = rd_cap ? rd_val : q.rdata;

		if (wr) begin
			unique case (idx)
				`PDT_IDX_DEADTIME: begin
					if (q.write_protect_disable) begin
						d.dt = wdat;
					end
				end
				`PDT_IDX_EXTTRIG: begin
					d.ext_en = wdat[6:0];
				end
				`PDT_IDX_POLARITY: begin
					if (q.write_protect_disable) begin
						d.pol = wdat;
					end
				end
				`PDT_IDX_CTRL: begin
					d.write_protect_disable    = wdat[`PDT_CTRL_WRITE_PROTECT_DISABLE];
					d.fault_en = wdat[`PDT_CTRL_FLTEN];
					if (q.write_protect_disable) begin
						d.pair_en = wdat[7:`PDT_CTRL_PAIR_DEADTIME_ENABLE_LSB];
					end
				end
				`PDT_IDX_STATUS: begin
					d.sts = q.sts & ~wdat[1:0];
				end
				`PDT_IDX_MASK: begin
					d.mask = wdat[1:0];
				end
				default: begin
				end
			endcase
		end

		// A read that returns the flag set arms the clear sequence.
		if (rd_cap && idx == `PDT_IDX_EXTTRIG && q.flag) begin
			d.arm = 1'b1;
		end
		if (wr && idx == `PDT_IDX_EXTTRIG) begin
			d.arm = 1'b0;
			if (!wdat[`PDT_TRIGGER_FLAG_BIT] && q.arm) begin
				d.flag = 1'b0;
			end
		end
		// A new channel trigger wins over any clear and restarts the sequence.
		if (chan_trig) begin
			d.flag = 1'b1;
			d.arm  = 1'b0;
		end

		if (chan_trig) begin
			d.sts[`PDT_STS_TRIG] = 1'b1;
		end
		if (fault_on) begin
			d.sts[`PDT_STS_FAULT] = 1'b1;
		end
		d.irq = |(q.sts & q.mask);

		for (int i = 0; i < 8; i++) begin
			if (fault_on) begin
				d.pwm[i] = q.pol[i];
			end else begin
				d.pwm[i] = dt_out[i] ^ q.pol[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q          <= '0;
			q.dt       <= `PDT_RST_BYTE;
			q.pol      <= `PDT_RST_BYTE;
			q.write_protect_disable    <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = {24'h000000, q.rdata};
	assign wb_ack_o = q.ack;
	assign pwm_o    = q.pwm;
	assign irq_o    = q.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_dt_protected: assert property (wr && idx == `PDT_IDX_DEADTIME && !q.write_protect_disable |=> $stable(q.dt))
		else $error("Deadtime register changed while protected.");
	chk_dt_written: assert property (wr && idx == `PDT_IDX_DEADTIME && q.write_protect_disable |=> q.dt == $past(wdat))
		else $error("Deadtime write lost while unprotected.");
	chk_pol_protected: assert property (wr && idx == `PDT_IDX_POLARITY && !q.write_protect_disable |=> $stable(q.pol))
		else $error("Polarity changed while protected.");
	chk_flag_sets: assert property (chan_trig |=> q.flag)
		else $error("Channel trigger did not set the flag.");
	chk_flag_clear_seq: assert property (wr && idx == `PDT_IDX_EXTTRIG && q.arm && !wdat[7] && !chan_trig
		|=> !q.flag)
		else $error("Armed zero write did not clear the flag.");
	chk_flag_one_write: assert property (wr && idx == `PDT_IDX_EXTTRIG && wdat[7] && q.flag |=> q.flag)
		else $error("Writing one cleared the flag.");
	chk_flag_unarmed: assert property (q.flag && !q.arm && !rd_cap |=> q.flag)
		else $error("Flag cleared without a qualifying read.");
	chk_retrigger_keeps: assert property (q.arm && chan_trig |=> q.flag && !q.arm)
		else $error("Trigger during clear sequence was lost.");
	chk_fault_safe: assert property (fault_on |=> pwm_o == $past(q.pol))
		else $error("Fault did not drive the safe state.");
	chk_polarity_out: assert property (!fault_on |=> pwm_o == ($past(dt_out) ^ $past(q.pol)))
		else $error("Output polarity wrong.");
	chk_wpon_inverse: assert property (rd_cap && idx == `PDT_IDX_CTRL |=> q.rdata[2] == !$past(q.write_protect_disable))
		else $error("Write protect status not inverse of disable.");
	chk_irq_level: assert property (q.sts[0] && q.mask[0] ##1 q.sts[0] |-> irq_o)
		else $error("Unmasked status did not raise the interrupt.");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held for more than one cycle.");

	// Protected fields move only through an accepted write.
	chk_dt_hold: assert property (!(wr && idx == `PDT_IDX_DEADTIME)
		|=> $stable(q.dt))
		else $error("Deadtime register changed without a write.");
	chk_write_protect_disable_written: assert property (wr && idx == `PDT_IDX_CTRL
		|=> q.write_protect_disable == $past(wdat[`PDT_CTRL_WRITE_PROTECT_DISABLE]))
		else $error("Protection disable bit not written.");
	chk_pol_hold: assert property (!(wr && idx == `PDT_IDX_POLARITY)
		|=> $stable(q.pol))
		else $error("Polarity changed without a write.");
	chk_pol_written: assert property (wr && idx == `PDT_IDX_POLARITY && q.write_protect_disable
		|=> q.pol == $past(wdat))
		else $error("Polarity write lost while unprotected.");
	chk_pair_deadtime_enable_locked: assert property (wr && idx == `PDT_IDX_CTRL && !q.write_protect_disable
		|=> $stable(q.pair_en))
		else $error("Pair deadtime enables changed while protected.");
	chk_pair_deadtime_enable_written: assert property (wr && idx == `PDT_IDX_CTRL && q.write_protect_disable
		|=> q.pair_en == $past(wdat[7:`PDT_CTRL_PAIR_DEADTIME_ENABLE_LSB]))
		else $error("Pair deadtime enable write lost.");
	chk_pair_deadtime_enable_hold: assert property (!(wr && idx == `PDT_IDX_CTRL)
		|=> $stable(q.pair_en))
		else $error("Pair deadtime enables changed without a write.");
	chk_pair0_bypass: assert property (!q.pair_en[0] && !fault_on
		|=> pwm_o[1:0] == ($past(pwm_i[1:0]) ^ $past(q.pol[1:0])))
		else $error("Disabled pair was delayed.");
	chk_active_low: assert property (!fault_on && (q.pol & ~dt_out) != 8'h00
		|=> (pwm_o & $past(q.pol & ~dt_out)) == $past(q.pol & ~dt_out))
		else $error("Active low channel not high while inactive.");
	chk_ext_written: assert property (wr && idx == `PDT_IDX_EXTTRIG
		|=> q.ext_en == $past(wdat[6:0]))
		else $error("Trigger enables not written.");
	chk_ext_hold: assert property (!(wr && idx == `PDT_IDX_EXTTRIG)
		|=> $stable(q.ext_en))
		else $error("Trigger enables changed without a write.");
	chk_init_on: assert property (q.ext_en[`PDT_INIT_EN_BIT] && init_match_i
		|=> trig_o)
		else $error("Enabled initialization match gave no trigger.");
	chk_init_off: assert property (!q.ext_en[`PDT_INIT_EN_BIT] && chan_match_i[5:0] == 6'h00
		|=> !trig_o)
		else $error("Trigger without an enabled source.");
	chk_chan0_map: assert property (q.ext_en[4] && chan_match_i[0]
		|=> chan_trig_o)
		else $error("Channel 0 match with its enable gave no trigger.");
	chk_chan2_map: assert property (q.ext_en[0] && chan_match_i[2]
		|=> chan_trig_o)
		else $error("Channel 2 match with its enable gave no trigger.");
	chk_chan5_map: assert property (q.ext_en[3] && chan_match_i[5]
		|=> chan_trig_o)
		else $error("Channel 5 match with its enable gave no trigger.");
	chk_chan_off: assert property ((q.ext_en[5:0] & {chan_match_i[1:0], chan_match_i[5:2]}) == 6'h00
		|=> !chan_trig_o)
		else $error("Channel trigger without an enabled match.");
	chk_upper_ignored: assert property (chan_match_i[5:0] == 6'h00
		|=> !chan_trig_o)
		else $error("Channel 6 or 7 raised a channel trigger.");
	chk_two_trigs: assert property ((q.ext_en[4] && chan_match_i[0]) ##1 (q.ext_en[5] && chan_match_i[1])
		|=> chan_trig_o && $past(chan_trig_o))
		else $error("Matches in separate cycles did not give separate triggers.");
	chk_flag_only_chan: assert property (!q.flag && !chan_trig
		|=> !q.flag)
		else $error("Flag set without a channel trigger.");
	chk_flag_rd_value: assert property (rd_cap && idx == `PDT_IDX_EXTTRIG
		|=> q.rdata == {$past(q.flag), $past(q.ext_en)})
		else $error("Trigger register read returned wrong data.");
	chk_flag_read_arms: assert property (rd_cap && idx == `PDT_IDX_EXTTRIG && q.flag && !chan_trig
		|=> q.arm)
		else $error("Read of the set flag did not arm the clear.");
	chk_arm_ends: assert property (wr && idx == `PDT_IDX_EXTTRIG
		|=> !q.arm)
		else $error("Clear sequence still armed after a write.");
	chk_arm_needs_flag: assert property (!q.arm && !(rd_cap && idx == `PDT_IDX_EXTTRIG && q.flag)
		|=> !q.arm)
		else $error("Clear sequence armed without a qualifying read.");
	chk_ctrl_read: assert property (rd_cap && idx == `PDT_IDX_CTRL
		|=> q.rdata[`PDT_CTRL_WPON] != q.rdata[`PDT_CTRL_WRITE_PROTECT_DISABLE])
		else $error("Write protect status equals the disable bit.");
	chk_trig_status: assert property (chan_trig
		|=> q.sts[`PDT_STS_TRIG])
		else $error("Channel trigger did not set its status bit.");
	chk_fault_status: assert property (fault_on
		|=> q.sts[`PDT_STS_FAULT])
		else $error("Fault did not set its status bit.");
	chk_status_w1c: assert property (wr && idx == `PDT_IDX_STATUS && wdat[0] && !chan_trig
		|=> !q.sts[`PDT_STS_TRIG])
		else $error("Writing one did not clear the status bit.");
	chk_status_kept: assert property (q.sts[0] && !(wr && idx == `PDT_IDX_STATUS && wdat[0])
		|=> q.sts[`PDT_STS_TRIG])
		else $error("Status bit cleared without a write of one.");
	chk_mask_written: assert property (wr && idx == `PDT_IDX_MASK
		|=> q.mask == $past(wdat[1:0]))
		else $error("Mask write lost.");
	chk_irq_off: assert property ((q.sts & q.mask) == 2'b00
		|=> !irq_o)
		else $error("Interrupt raised with no unmasked status.");
	chk_ack_answer: assert property (req && !wb_ack_o
		|=> wb_ack_o)
		else $error("Request not acknowledged in one cycle.");
	chk_ack_needs_req: assert property (!req
		|=> !wb_ack_o)
		else $error("Acknowledge without a request.");
	chk_unmapped_zero: assert property (rd_cap && !(idx inside {`PDT_IDX_DEADTIME, `PDT_IDX_EXTTRIG,
		`PDT_IDX_POLARITY, `PDT_IDX_CTRL, `PDT_IDX_STATUS, `PDT_IDX_MASK}) |=> q.rdata == 8'h00)
		else $error("Unmapped read returned nonzero data.");
endmodule : pdt_top
`default_nettype wire

// ---- testbench/pdt_trig_sink.sv ----
// Purpose: Trigger consumer at the far side; it counts trigger pulses.
// Assumes: Trigger outputs are one-cycle pulses.
// Notes:   Counts clear on reset.
`timescale 1ns/1ps
`default_nettype none
module pdt_trig_sink (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        trig_i,
	input  wire logic        chan_trig_i,
	output logic      [15:0] n_trig_o,
	output logic      [15:0] n_chan_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			n_trig_o <= 16'h0000;
			n_chan_o <= 16'h0000;
		end else begin
			n_trig_o <= n_trig_o + 16'(trig_i);
			n_chan_o <= n_chan_o + 16'(chan_trig_i);
		end
	end
endmodule : pdt_trig_sink
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the deadtime, trigger and polarity block.
// Assumes: Reads are checked by a monitor against a queue of expected bytes.
// Notes:   Measured delays include one sampling edge.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_map.svh"
module testbench;
	logic        clk_i        = 1'b0;
	logic        rst_i        = 1'b1;
	logic [9:0]  wb_adr       = '0;
	logic [31:0] wb_wdat      = '0;
	logic [3:0]  wb_sel       = '0;
	logic        wb_we        = 1'b0;
	logic        wb_cyc       = 1'b0;
	logic        wb_stb       = 1'b0;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic [7:0]  pwm_in       = '0;
	logic [7:0]  chan_match   = '0;
	logic        init_match   = 1'b0;
	logic        fault        = 1'b0;
	logic [7:0]  pwm_out;
	logic        trig;
	logic        chan_trig;
	logic        irq;
	logic [15:0] n_trig;
	logic [15:0] n_chan;
	logic [7:0]  exp_q[$];
	int          bad_count    = 0;
	int          cmp_count    = 0;
	int          ch_of_bit[6] = '{2, 3, 4, 5, 0, 1};
	logic [7:0]  dt_tab[6]    = '{8'h02, 8'h42, 8'h82, 8'hc2, 8'h00, 8'hc2};
	int          dt_cyc[6]    = '{2, 2, 8, 32, 0, 0};

	always #12.5 clk_i = ~clk_i;

	pdt_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel),
		.wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.pwm_i(pwm_in), .init_match_i(init_match), .chan_match_i(chan_match), .fault_i(fault),
		.pwm_o(pwm_out), .trig_o(trig), .chan_trig_o(chan_trig), .irq_o(irq));

	pdt_trig_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .trig_i(trig), .chan_trig_i(chan_trig),
		.n_trig_o(n_trig), .n_chan_o(n_chan));

	task automatic test_done;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= we;
		wb_adr  <= {idx, 2'b00};
		wb_wdat <= {24'h0, d};
		wb_sel  <= 4'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			test_done();
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask : wb_xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb_xfer(1'b1, idx, d);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		exp_q.push_back(e);
		wb_xfer(1'b0, idx, 8'h00);
	endtask : rd

	task automatic pulse(input logic [7:0] ch, input logic init);
		@(posedge clk_i);
		chan_match <= ch;
		init_match <= init;
		@(posedge clk_i);
		chan_match <= 8'h00;
		init_match <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : pulse

	task automatic wait_pwm(input int ch, input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pwm_out[ch] !== v && n < 100);
		if (n >= 100) begin
			bad_count++;
			test_done();
		end
	endtask : wait_pwm

	always @(posedge clk_i) begin
		if (wb_ack === 1'b1 && wb_we === 1'b0) begin
			if (exp_q.size() == 0) begin
				check(wb_rdat, 32'hffffffff);
			end else begin
				check(wb_rdat, {24'h0, exp_q.pop_front()});
			end
		end
	end

	initial begin
		int         n;
		int         ec;
		int         ea;
		int         ch;
		logic [7:0] r;
		logic [7:0] p;
		void'($urandom(32'ha6dec046));
		ec = 0;
		ea = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(`PDT_IDX_DEADTIME, 8'hff);
		wr(`PDT_IDX_POLARITY, 8'hff);
		wr(`PDT_IDX_CTRL, 8'hf0);
		rd(`PDT_IDX_DEADTIME, 8'h00);
		rd(`PDT_IDX_POLARITY, 8'h00);
		rd(`PDT_IDX_EXTTRIG, 8'h00);
		rd(`PDT_IDX_CTRL, 8'h04);
		rd(8'h40, 8'h00);
		wr(`PDT_IDX_CTRL, 8'h01);
		rd(`PDT_IDX_CTRL, 8'h01);
		r = 8'($urandom);
		p = 8'($urandom);
		wr(`PDT_IDX_DEADTIME, r);
		wr(`PDT_IDX_POLARITY, p);
		wr(`PDT_IDX_CTRL, 8'h02);
		wr(`PDT_IDX_DEADTIME, ~r);
		wr(`PDT_IDX_POLARITY, ~p);
		rd(`PDT_IDX_DEADTIME, r);
		rd(`PDT_IDX_POLARITY, p);
		pwm_in <= 8'($urandom);
		repeat (3) @(posedge clk_i);
		check(32'(pwm_out), 32'(pwm_in ^ p));
		fault <= 1'b1;
		repeat (3) @(posedge clk_i);
		check(32'(pwm_out), 32'(p));
		fault  <= 1'b0;
		pwm_in <= 8'h00;
		for (int b = 0; b < 6; b++) begin
			wr(`PDT_IDX_EXTTRIG, 8'(1 << b));
			for (int c = 0; c < 8; c++) begin
				pulse(8'(1 << c), 1'b0);
				if (c == ch_of_bit[b]) begin
					ec++;
				end
				check(32'(n_chan), 32'(ec));
			end
		end
		ea = ec;
		wr(`PDT_IDX_EXTTRIG, 8'h3f);
		@(posedge clk_i);
		chan_match <= 8'h01;
		@(posedge clk_i);
		chan_match <= 8'h02;
		@(posedge clk_i);
		chan_match <= 8'h00;
		repeat (3) @(posedge clk_i);
		ec += 2;
		ea += 2;
		check(32'(n_chan), 32'(ec));
		wr(`PDT_IDX_EXTTRIG, 8'h40);
		pulse(8'h00, 1'b1);
		ea++;
		check(32'(n_trig), 32'(ea));
		check(32'(n_chan), 32'(ec));
		wr(`PDT_IDX_EXTTRIG, 8'h00);
		pulse(8'h00, 1'b1);
		check(32'(n_trig), 32'(ea));
		// Flag clear needs a read of the set flag before the zero write.
		rd(`PDT_IDX_EXTTRIG, 8'h80);
		wr(`PDT_IDX_EXTTRIG, 8'h10);
		rd(`PDT_IDX_EXTTRIG, 8'h10);
		wr(`PDT_IDX_EXTTRIG, 8'h90);
		rd(`PDT_IDX_EXTTRIG, 8'h10);
		pulse(8'h01, 1'b0);
		rd(`PDT_IDX_EXTTRIG, 8'h90);
		pulse(8'h01, 1'b0);
		wr(`PDT_IDX_EXTTRIG, 8'h10);
		rd(`PDT_IDX_EXTTRIG, 8'h90);
		wr(`PDT_IDX_MASK, 8'h01);
		repeat (3) @(posedge clk_i);
		check(32'(irq), 32'h1);
		wr(`PDT_IDX_MASK, 8'h00);
		repeat (3) @(posedge clk_i);
		check(32'(irq), 32'h0);
		wr(`PDT_IDX_MASK, 8'h01);
		wr(`PDT_IDX_STATUS, 8'h01);
		rd(`PDT_IDX_STATUS, 8'h02);
		check(32'(irq), 32'h0);
		wr(`PDT_IDX_CTRL, 8'h01);
		wr(`PDT_IDX_POLARITY, 8'h00);
		for (int i = 0; i < 6; i++) begin
			ch = 2 * (i % 4);
			wr(`PDT_IDX_DEADTIME, dt_tab[i]);
			wr(`PDT_IDX_CTRL, (i < 5) ? 8'(8'h01 | (8'h10 << (i % 4))) : 8'h01);
			pwm_in[ch] <= 1'b1;
			wait_pwm(ch, 1'b1, n);
			check(32'(n), 32'(dt_cyc[i] + 2));
			pwm_in[ch] <= 1'b0;
			wait_pwm(ch, 1'b0, n);
			check(32'(n), 32'd2);
		end
		repeat (3) @(posedge clk_i);
		check(32'(exp_q.size()), 32'd0);
		test_done();
	end
endmodule : testbench
`default_nettype wire
